// >>> rtl/mcap_port.sv
// Purpose: parallel host port of a simultaneous-sampling multichannel converter
// Assumes: host pins are asynchronous to sys_clk; strobes low for several cycles
// Notes: NUM_CH is the variant channel count, 4, 6 or 8
`timescale 1ns/100ps
`default_nettype none

module mcap_port #(
  parameter int NUM_CH = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic chipSelN,
  input wire logic readN,
  input wire logic writeN,
  input wire logic sample_convert_start,
  input wire logic power_down_in,
  input wire logic cfg_bit_1,
  input wire logic cfg_bit_0,
  input wire logic [mcap_pkg::DATA_W-1:0] dataIn,
  output logic [mcap_pkg::DATA_W-1:0] dataOut,
  output logic dataOe,
  output logic eocN,
  output logic [mcap_pkg::CFG_W-1:0] cfgOut,
  output logic lowPower,
  input wire logic [NUM_CH*mcap_pkg::DATA_W-1:0] chanSampleIn
);

  localparam logic [mcap_pkg::PTR_W-1:0] PTR_LAST = mcap_pkg::PTR_W'(NUM_CH - 1);
  localparam logic [mcap_pkg::PTR_W-1:0] PTR_ONE = 3'h1;

  typedef struct packed {
    logic [mcap_pkg::SYNC_W-1:0] s1;
    logic [mcap_pkg::SYNC_W-1:0] s2;
    logic [mcap_pkg::SYNC_W-1:0] prev;
    logic [mcap_pkg::CFG_W-1:0] cfg;
    logic [mcap_pkg::PTR_W-1:0] ptr;
    logic [mcap_pkg::DATA_W-1:0] dataOut;
    logic dataOe;
  } mcap_port_st_t;

  localparam mcap_port_st_t ST_RST = '{
    s1: mcap_pkg::SYNC_RST,
    s2: mcap_pkg::SYNC_RST,
    prev: mcap_pkg::SYNC_RST,
    cfg: mcap_pkg::CFG_RST,
    ptr: '0,
    dataOut: '0,
    dataOe: 1'b0
  };

  mcap_port_st_t q;
  mcap_port_st_t d;

  mcap_if cv ();

  logic [mcap_pkg::SYNC_W-1:0] pinVec;
  logic csLow;
  logic rdLow;
  logic rdRise;
  logic wrRise;
  logic cvRise;
  logic pdOn;
  logic startAcc;
  logic cfgWrite;
  logic rdStep;

  assign pinVec = {chipSelN, readN, writeN, sample_convert_start, power_down_in,
                   cfg_bit_1, cfg_bit_0, dataIn[1], dataIn[0]};

  // edges are taken from the second stage against the third, never from the first
  assign csLow = !q.s2[mcap_pkg::S_CS];
  assign rdLow = !q.s2[mcap_pkg::S_RD];
  assign rdRise = q.s2[mcap_pkg::S_RD] && !q.prev[mcap_pkg::S_RD];
  assign wrRise = q.s2[mcap_pkg::S_WR] && !q.prev[mcap_pkg::S_WR];
  assign cvRise = q.s2[mcap_pkg::S_CV] && !q.prev[mcap_pkg::S_CV];
  assign pdOn = q.s2[mcap_pkg::S_PD];

  // a start during a running conversion or in power-down is dropped
  assign startAcc = cvRise && !pdOn && !cv.busy;
  // the host holds chip select across the strobe edge
  assign cfgWrite = wrRise && csLow && !pdOn;
  assign rdStep = rdRise && csLow && !startAcc;

  always_comb begin
    d = q;
    d.s1 = pinVec;
    d.s2 = q.s1;
    d.prev = q.s2;

    if (cfgWrite) begin
      d.cfg = {q.s2[mcap_pkg::S_D1], q.s2[mcap_pkg::S_D0],
               q.s2[mcap_pkg::S_C1], q.s2[mcap_pkg::S_C0]};
    end

    if (startAcc) begin
      d.ptr = '0;
    end else if (rdStep) begin
      if (q.ptr == PTR_LAST) begin
        d.ptr = '0;
      end else begin
        d.ptr = q.ptr + PTR_ONE;
      end
    end

    // bus driven only while the host reads; otherwise it is left to the host
    d.dataOe = csLow && rdLow && !pdOn;
    d.dataOut = cv.rdData;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign cv.startStrobe = startAcc;
  assign cv.rdIdx = q.ptr;

  mcap_conv #(
    .NUM_CH(NUM_CH)
  ) u_conv (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .chanSampleIn(chanSampleIn),
    .cv(cv.conv)
  );

  assign dataOut = q.dataOut;
  assign dataOe = q.dataOe;
  assign eocN = !cv.done;
  assign cfgOut = q.cfg;
  assign lowPower = pdOn;

  a_cfg_capture: assert property (@(posedge sys_clk) disable iff (!resetn)
    cfgWrite |=> cfgOut == {$past(q.s2[mcap_pkg::S_D1]), $past(q.s2[mcap_pkg::S_D0]),
                            $past(q.s2[mcap_pkg::S_C1]), $past(q.s2[mcap_pkg::S_C0])})
    else $error("configuration not loaded from the bus");

  a_cfg_steady: assert property (@(posedge sys_clk) disable iff (!resetn)
    !cfgWrite |=> $stable(cfgOut))
    else $error("configuration changed without a write");

  a_ptr_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rdStep && (q.ptr != PTR_LAST)) |=> q.ptr == $past(q.ptr) + PTR_ONE)
    else $error("read strobe did not step to the next channel");

  a_ptr_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rdStep && (q.ptr == PTR_LAST)) |=> q.ptr == '0)
    else $error("read sequence did not wrap after the last channel");

  a_ptr_range: assert property (@(posedge sys_clk) disable iff (!resetn)
    q.ptr <= PTR_LAST)
    else $error("channel pointer beyond channel count");

  a_bus_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
    dataOe |-> $past(csLow) && $past(rdLow) && !$past(pdOn))
    else $error("bus driven outside a read");

  a_ptr_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
    startAcc |=> (q.ptr == '0) ##1 (q.ptr == '0) || $past(rdStep))
    else $error("pointer not at channel zero after start");

  a_pd_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    pdOn |=> $stable(cfgOut) && (!cv.busy || $past(cv.busy)))
    else $error("configuration lost or conversion begun in power-down");

  a_start_conv: assert property (@(posedge sys_clk) disable iff (!resetn)
    startAcc |=> cv.busy && eocN ##1 cv.busy [*3])
    else $error("start edge did not begin a conversion");

  a_eoc_rise: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(eocN) |-> $past(startAcc))
    else $error("done output rose without a new start");

  // a running conversion is never restarted, so its results cannot be cut short
  a_start_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    cv.startStrobe |-> !cv.busy)
    else $error("start passed to a busy engine");

  a_start_pd: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cvRise && pdOn && !cv.busy) |=> !cv.busy)
    else $error("conversion begun in power-down");

  a_wr_refused: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wrRise && pdOn) |=> $stable(cfgOut))
    else $error("configuration written in power-down");

  a_oe_pd: assert property (@(posedge sys_clk) disable iff (!resetn)
    pdOn |=> !dataOe)
    else $error("bus driven in power-down");

  a_bus_release: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!csLow || !rdLow) |=> !dataOe)
    else $error("bus not released after the read");

  a_bus_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    (csLow && rdLow && !pdOn) |=> dataOe)
    else $error("bus not driven during a read");

  a_ptr_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!rdStep && !startAcc) |=> $stable(q.ptr))
    else $error("channel pointer moved without a read edge");

  a_busy_eoc: assert property (@(posedge sys_clk) disable iff (!resetn)
    cv.busy |-> eocN)
    else $error("done output low during a conversion");

  a_eoc_fall: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(eocN) |-> $past(cv.busy) && !cv.busy)
    else $error("done output fell without a finished conversion");

  a_eoc_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!eocN && !startAcc) |=> !eocN)
    else $error("done output rose without a start");

endmodule // mcap_port

`default_nettype wire

// >>> rtl/mcap_pkg.sv
// Purpose: shared constants for the multichannel converter parallel host port
// Assumes: 100 MHz sys_clk, synchronous active-low reset
// Notes: the host bus pins are asynchronous and are synchronised inside the top module
// Summary of operation
// - The configuration register is loaded at the rising edge of the write strobe while chip select is low.
// - Each low read-strobe period shows one channel result, and its rising edge steps to the next channel.
// - All channels convert in parallel and their results become readable once the conversion time has elapsed after the sample ends.
// - The data bus is two-way: results are driven out during reads and configuration bits are taken in during writes.
// - The channel count is four, six or eight per variant, and the read sequence steps through exactly that many results.
// - The active-low conversion-done output goes low when a conversion completes and high when a new one starts.
// - The rising edge of the sample-convert start input ends sampling and starts converting the captured samples.
// - While power-down is high no new conversion starts, writes and bus drive are refused, and the configuration register contents are kept.
// - Configuration bits 3 and 2 come from data bus bits 1 and 0, and bits 1 and 0 from their own inputs.

package mcap_pkg;

  localparam int DATA_W = 14;
  localparam int CH_MAX = 8;
  localparam int PTR_W = 3;
  localparam int CFG_W = 4;
  localparam logic [CFG_W-1:0] CFG_RST = 4'h0;

  // conversion time, a least time, so the cycle count rounds up
  localparam int CONV_TIME_NS = 3000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = 9'h001;

  // synchroniser vector layout
  localparam int SYNC_W = 9;
  localparam int S_CS = 8;
  localparam int S_RD = 7;
  localparam int S_WR = 6;
  localparam int S_CV = 5;
  localparam int S_PD = 4;
  localparam int S_C1 = 3;
  localparam int S_C0 = 2;
  localparam int S_D1 = 1;
  localparam int S_D0 = 0;
  // strobes and start idle high, so no false edge follows reset
  localparam logic [SYNC_W-1:0] SYNC_RST = 9'h1e0;

endpackage : mcap_pkg

// >>> rtl/mcap_if.sv
// Purpose: link between the host port logic and the conversion engine
// Assumes: both ends clocked by sys_clk
// Notes: rdData is combinational from the result store
`timescale 1ns/100ps
`default_nettype none

interface mcap_if;
  logic startStrobe;
  logic busy;
  logic done;
  logic [mcap_pkg::PTR_W-1:0] rdIdx;
  logic [mcap_pkg::DATA_W-1:0] rdData;

  modport port (output startStrobe, output rdIdx, input busy, input done, input rdData);
  modport conv (input startStrobe, input rdIdx, output busy, output done, output rdData);
endinterface : mcap_if

`default_nettype wire

// >>> rtl/mcap_conv.sv
// Purpose: parallel conversion engine with per-channel hold and result store
// Assumes: samples arrive in the sys_clk domain and are steady around the start strobe
// Notes: a start while busy is not accepted by the port logic
`timescale 1ns/100ps
`default_nettype none

module mcap_conv #(
  parameter int NUM_CH = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [NUM_CH*mcap_pkg::DATA_W-1:0] chanSampleIn,
  mcap_if.conv cv
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [mcap_pkg::CNT_W-1:0] cnt;
    logic [NUM_CH-1:0][mcap_pkg::DATA_W-1:0] held;
    logic [NUM_CH-1:0][mcap_pkg::DATA_W-1:0] result;
  } mcap_conv_st_t;

  mcap_conv_st_t q;
  mcap_conv_st_t d;
  logic [mcap_pkg::CNT_W:0] busyLen;

  always_comb begin
    d = q;
    if (cv.startStrobe) begin
      // every channel is captured in the same cycle, then converted together
      d.busy = 1'b1;
      d.done = 1'b0;
      d.cnt = mcap_pkg::CONV_LOAD;
      d.held = chanSampleIn;
    end else if (q.busy) begin
      if (q.cnt == mcap_pkg::CNT_LAST) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.result = q.held;
      end else begin
        d.cnt = q.cnt - mcap_pkg::CNT_LAST;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cv.busy = q.busy;
  assign cv.done = q.done;
  assign cv.rdData = q.result[cv.rdIdx];

  // helper: length of the current busy stretch
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      busyLen <= '0;
    end else if (cv.startStrobe) begin
      busyLen <= '0;
    end else if (q.busy) begin
      busyLen <= busyLen + 10'h001;
    end
  end

  a_conv_time: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(q.busy) |-> (busyLen == 10'(mcap_pkg::CONV_CYCLES)) && q.done)
    else $error("conversion length differs from the conversion time");

  a_done_result: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(q.done) |-> $past(q.busy) && !q.busy && (q.result == $past(q.held)))
    else $error("done raised without a finished conversion");

endmodule // mcap_conv

`default_nettype wire

// >>> test/mcap_host.sv
// Purpose: host processor model on the parallel strobe bus
// Assumes: tasks are entered 1 ns after a sys_clk rising edge
// Notes: an undriven bus shows the inverse of its last level, so stale data cannot pass
`timescale 1ns/100ps
`default_nettype none

module mcap_host (
  input wire logic sys_clk,
  input wire logic dataOe,
  input wire logic [mcap_pkg::DATA_W-1:0] dataOut,
  output logic chipSelN,
  output logic readN,
  output logic writeN,
  output logic [mcap_pkg::DATA_W-1:0] dataIn
);
  logic drvEn = 1'b0;
  logic [mcap_pkg::DATA_W-1:0] drvVal = '0;
  logic [mcap_pkg::DATA_W-1:0] lastBus = '0;
  initial begin
    chipSelN = 1'b1;
    readN = 1'b1;
    writeN = 1'b1;
  end
  always_comb dataIn = dataOe ? dataOut : (drvEn ? drvVal : ~lastBus);
  always @(posedge sys_clk) lastBus <= dataIn;

  // chip select stays low across the strobe and its rising edge
  task automatic hostWrite(input logic [1:0] hi);
    chipSelN = 1'b0;
    writeN = 1'b0;
    drvEn = 1'b1;
    drvVal = {12'h000, hi};
    repeat (5) @(posedge sys_clk);
    #1 writeN = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chipSelN = 1'b1;
    drvEn = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic hostRead(output logic [mcap_pkg::DATA_W-1:0] d, output logic oe);
    chipSelN = 1'b0;
    readN = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 d = dataIn;
    oe = dataOe;
    repeat (2) @(posedge sys_clk);
    #1 readN = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 chipSelN = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
endmodule // mcap_host

`default_nettype wire

// >>> test/test_multichannel_adc_parallel_port.sv
// Purpose: self-checking bench for the converter host port
// Assumes: six-channel variant, inputs driven 1 ns after the rising edge
// Notes: a six-channel build exercises a wrap that is not a power of two
`timescale 1ns/100ps
`default_nettype none

module test_multichannel_adc_parallel_port;
  localparam int NCH = 6;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic startIn = 1'b0;
  logic pdIn = 1'b0;
  logic cfg1 = 1'b0;
  logic cfg0 = 1'b0;
  logic [NCH*mcap_pkg::DATA_W-1:0] samples = '0;
  logic chipSelN, readN, writeN, dataOe, eocN, lowPower;
  logic [mcap_pkg::DATA_W-1:0] dataIn, dataOut;
  logic [mcap_pkg::CFG_W-1:0] cfgOut;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  mcap_port #(.NUM_CH(NCH)) DUT (.sys_clk(sys_clk), .resetn(resetn), .chipSelN(chipSelN),
    .readN(readN), .writeN(writeN), .sample_convert_start(startIn), .power_down_in(pdIn),
    .cfg_bit_1(cfg1), .cfg_bit_0(cfg0), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .eocN(eocN), .cfgOut(cfgOut), .lowPower(lowPower), .chanSampleIn(samples));
  mcap_host host (.sys_clk(sys_clk), .dataOe(dataOe), .dataOut(dataOut), .chipSelN(chipSelN),
    .readN(readN), .writeN(writeN), .dataIn(dataIn));

  task automatic print_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // about 1000 cycles of traffic; the ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic check(input logic [13:0] got, input logic [13:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic test_reset();
    check({13'h0, eocN}, 14'h1, "eocN after reset");
    check({13'h0, dataOe}, 14'h0, "bus released after reset");
    check({10'h0, cfgOut}, {10'h0, mcap_pkg::CFG_RST}, "cfg after reset");
    check({13'h0, lowPower}, 14'h0, "lowPower after reset");
  endtask

  task automatic test_config();
    for (int k = 0; k < 16; k++) begin
      cfg1 = k[1];
      cfg0 = k[0];
      host.hostWrite(k[3:2]);
      check({10'h0, cfgOut}, 14'(k), "cfg write");
    end
  endtask

  // a second start edge mid-conversion must be ignored
  task automatic test_convert(input logic [13:0] base);
    int n;
    for (int k = 0; k < NCH; k++) samples[k*14 +: 14] = base + 14'(k);
    startIn = 1'b1;
    n = 0;
    // the done output of an earlier conversion may still be low for the first cycles
    while (n < 400 && (n < 4 || eocN !== 1'b0)) begin
      step(1);
      n++;
      if (n == 3) check({13'h0, eocN}, 14'h1, "eocN high at start");
      if (n == 5) samples = ~samples;
      if (n == 50) startIn = 1'b0;
      if (n == 100) startIn = 1'b1;
    end
    check(14'(n), 14'(mcap_pkg::CONV_CYCLES + 3), "cycles to done");
    startIn = 1'b0;
    step(4);
  endtask

  task automatic test_read(input int cnt, input int first, input logic [13:0] base);
    logic [13:0] d;
    logic oe;
    for (int i = 0; i < cnt; i++) begin
      host.hostRead(d, oe);
      check({13'h0, oe}, 14'h1, "bus driven in read");
      check(d, base + 14'((first + i) % NCH), "channel result");
      check({13'h0, dataOe}, 14'h0, "bus released after read");
    end
  endtask

  task automatic test_power_down();
    pdIn = 1'b1;
    step(5);
    check({13'h0, lowPower}, 14'h1, "lowPower follows input");
    cfg1 = 1'b0;
    cfg0 = 1'b0;
    host.hostWrite(2'b00);
    check({10'h0, cfgOut}, 14'hf, "cfg kept in power-down");
    startIn = 1'b1;
    step(10);
    check({13'h0, eocN}, 14'h0, "start refused in power-down");
    startIn = 1'b0;
    pdIn = 1'b0;
    step(5);
    check({10'h0, cfgOut}, 14'hf, "cfg kept after power-down");
    check({13'h0, lowPower}, 14'h0, "lowPower released");
  endtask

  initial begin
    step(12);
    resetn = 1'b1;
    step(3);
    test_reset();
    test_config();
    test_convert(14'h0100);
    test_read(NCH + 1, 0, 14'h0100);
    test_read(2, 1, 14'h0100);
    test_convert(14'h0200);
    test_read(1, 0, 14'h0200);
    test_power_down();
    print_verdict();
  end
endmodule // test_multichannel_adc_parallel_port

`default_nettype wire
